// [logic/dforc_pkg.sv]
// constants, enumerations and carriers of the offset and retransmit controller
package dforc_pkg;

	// data path and memory geometry
	localparam int DATA_W = 18;
	localparam int ADDR_W = 17;
	localparam int PTR_W = 18;
	localparam logic [PTR_W-1:0] DEPTH = 18'h2_0000;
	localparam logic [PTR_W-1:0] HALF_DEPTH = 18'h1_0000;
	localparam logic [PTR_W-1:0] PTR_STEP = 18'h0_0001;
	localparam logic [PTR_W-1:0] PTR_ZERO = 18'h0_0000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 18'h0_0000;

	// offset split: low register carries the low bits, high register the rest
	localparam int OFS_LO_W = 16;
	localparam int OFS_HI_W = 1;
	localparam int OFS_W = OFS_LO_W + OFS_HI_W;
	localparam logic [OFS_W-1:0] OFS_DEF_PAR = 17'h0_007F;
	localparam logic [OFS_W-1:0] OFS_DEF_SER = 17'h0_03FF;

	// offset register pointer: 0 empty low, 1 empty high, 2 full low, 3 full high
	localparam logic [1:0] OPTR_EMPTY_LO = 2'h0;
	localparam logic [1:0] OPTR_FULL_HI = 2'h3;
	localparam logic [1:0] OPTR_STEP = 2'h1;
	localparam int OPTR_HI_BIT = 0;
	localparam int OPTR_SEL_BIT = 1;
	localparam logic OFS_SEL_EMPTY = 1'b0;
	localparam logic OFS_SEL_FULL = 1'b1;

	// mode and programming method encodings
	localparam logic MODE_STD = 1'b0;
	localparam logic METHOD_PAR = 1'b0;

	// retransmit setup lasts RT_SETUP_LAST + 1 read cycles
	localparam logic [1:0] RT_SETUP_LAST = 2'h1;
	localparam logic [1:0] RT_CNT_ZERO = 2'h0;
	localparam logic [1:0] RT_CNT_STEP = 2'h1;

	// reset levels of the partial and half flags and of the reset synchronisers
	localparam logic PAE_RST = 1'b0;
	localparam logic PAF_RST = 1'b1;
	localparam logic HF_RST = 1'b1;
	localparam logic SYNC_RST = 1'b0;

	typedef enum logic {
		RT_IDLE,
		RT_SETUP
	} dforc_rt_state_t;

	typedef struct packed {
		logic empty_flag_n;
		logic full_flag_n;
		logic half_full_flag_n;
		logic almost_empty_flag_n;
		logic almost_full_flag_n;
	} dforc_flags_t;

	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dforc_mem_wr_t;

endpackage : dforc_pkg

// [logic/dforc_ctrl.sv]
// offset programming, offset read-back, retransmit and reset control of the deep fifo
`timescale 1ns/10ps
`default_nettype none

module dforc_ctrl
	import dforc_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic master_reset_n_in,
	input wire logic partial_reset_n_in,
	input wire logic fall_through_select_in,
	input wire logic load_select_n_in,
	input wire logic write_en_n_in,
	input wire logic read_en_n_in,
	input wire logic retransmit_n_in,
	input wire logic [DATA_W-1:0] data_in_bus_in,
	input wire logic [DATA_W-1:0] mem_rd_data_in,
	output logic [DATA_W-1:0] data_out_bus_out,
	output wire dforc_flags_t flags_out,
	output var dforc_mem_wr_t mem_wr_out,
	output wire logic [ADDR_W-1:0] mem_rd_addr_out,
	output logic fall_through_mode_out,
	output logic serial_method_out
);

	function automatic logic [OFS_W-1:0] ofs_value(input logic [OFS_HI_W-1:0] hi,
		input logic [OFS_LO_W-1:0] lo);
		ofs_value = {hi, lo};
	endfunction : ofs_value

	function automatic logic [DATA_W-1:0] pad_word(input logic [OFS_W-1:0] v, input logic hi_half);
		logic [DATA_W-1:0] w;
		w = DATA_ZERO;
		if (hi_half) begin
			w[OFS_HI_W-1:0] = v[OFS_W-1:OFS_LO_W];
		end else begin
			w[OFS_LO_W-1:0] = v[OFS_LO_W-1:0];
		end
		pad_word = w;
	endfunction : pad_word

	// asynchronous reset trees; flops take only constants under them
	wire logic mrst_n = resetn_in & master_reset_n_in;
	wire logic prst_n = mrst_n & partial_reset_n_in;

	// three-stage synchronisers, a change counts once stages two and three agree
	logic mrs_s1, mrs_s2, mrs_s3, mrs_low;
	logic prs_s1, prs_s2, prs_s3, prs_low;
	wire logic rst_active = mrs_low | prs_low;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mrs_s1 <= SYNC_RST;
			mrs_s2 <= SYNC_RST;
			mrs_s3 <= SYNC_RST;
			prs_s1 <= SYNC_RST;
			prs_s2 <= SYNC_RST;
			prs_s3 <= SYNC_RST;
			mrs_low <= !SYNC_RST;
			prs_low <= !SYNC_RST;
		end else begin
			mrs_s1 <= master_reset_n_in;
			mrs_s2 <= mrs_s1;
			mrs_s3 <= mrs_s2;
			prs_s1 <= partial_reset_n_in;
			prs_s2 <= prs_s1;
			prs_s3 <= prs_s2;
			if (mrs_s2 == mrs_s3) begin
				mrs_low <= !mrs_s3;
			end
			if (prs_s2 == prs_s3) begin
				prs_low <= !prs_s3;
			end
		end
	end

	// configuration and offset storage
	logic fall_through_select_mode;
	logic serial_method;
	logic [OFS_LO_W-1:0] ofs_lo [2];
	logic [OFS_HI_W-1:0] ofs_hi [2];
	logic [1:0] ofs_wptr;
	logic [1:0] ofs_rptr;

	wire logic [OFS_W-1:0] empty_ofs = ofs_value(ofs_hi[OFS_SEL_EMPTY], ofs_lo[OFS_SEL_EMPTY]);
	wire logic [OFS_W-1:0] full_ofs = ofs_value(ofs_hi[OFS_SEL_FULL], ofs_lo[OFS_SEL_FULL]);
	wire logic [OFS_W-1:0] def_ofs = load_select_n_in ? OFS_DEF_SER : OFS_DEF_PAR;
	wire logic rd_sel = ofs_rptr[OPTR_SEL_BIT];
	wire logic [DATA_W-1:0] ofs_rd_word = pad_word(ofs_value(ofs_hi[rd_sel], ofs_lo[rd_sel]),
		ofs_rptr[OPTR_HI_BIT]);

	// datapath state
	logic [PTR_W-1:0] wptr;
	logic [PTR_W-1:0] wptr_vis;
	logic [PTR_W-1:0] rptr;
	logic out_valid;
	dforc_rt_state_t rt_state, next_rt_state;
	logic [1:0] rt_cnt;

	wire logic rt_idle = (rt_state == RT_IDLE);
	wire logic [PTR_W-1:0] mem_count = wptr_vis - rptr;
	wire logic [PTR_W-1:0] wr_count = wptr - rptr;
	wire logic mem_nonempty = (mem_count != PTR_ZERO);
	wire logic wfull = (wr_count == DEPTH);

	// request decode
	wire logic rt_start = rt_idle & !retransmit_n_in & read_en_n_in & write_en_n_in;
	wire logic rd_req = rt_idle & !read_en_n_in & load_select_n_in;
	wire logic ofs_rd = rt_idle & !read_en_n_in & !load_select_n_in;
	wire logic ofs_wr = !write_en_n_in & !load_select_n_in & (serial_method == METHOD_PAR)
		& !mrs_low;
	wire logic mem_wr = !write_en_n_in & load_select_n_in & !wfull;
	wire logic mem_rd_std = !fall_through_select_mode & rd_req & mem_nonempty;
	wire logic fall_through_select_pop = fall_through_select_mode & rd_req & out_valid;
	wire logic fall_through_select_load = fall_through_select_mode & rt_idle & mem_nonempty & !ofs_rd
		& (!out_valid | fall_through_select_pop);
	wire logic rd_take = mem_rd_std | fall_through_select_load;

	// next values
	wire logic [PTR_W-1:0] next_rptr = rt_start ? PTR_ZERO
		: (rd_take ? rptr + PTR_STEP : rptr);
	wire logic next_out_valid = !rt_start & !ofs_rd & (fall_through_select_load | (out_valid & !fall_through_select_pop));
	wire logic [DATA_W-1:0] next_data_out = ofs_rd ? ofs_rd_word
		: (rd_take ? mem_rd_data_in : data_out_bus_out);
	wire logic [1:0] next_rt_cnt = rt_start ? RT_SETUP_LAST
		: (rt_cnt != RT_CNT_ZERO ? rt_cnt - RT_CNT_STEP : rt_cnt);
	wire logic next_rt_busy = (next_rt_state == RT_SETUP);

	always_comb begin
		next_rt_state = rt_state;
		case (rt_state)
			RT_IDLE: begin
				if (rt_start) begin
					next_rt_state = RT_SETUP;
				end
			end
			RT_SETUP: begin
				if (rt_cnt == RT_CNT_ZERO) begin
					next_rt_state = RT_IDLE;
				end
			end
			default: begin
				next_rt_state = RT_IDLE;
			end
		endcase
	end

	// flag thresholds; fall-through counts the output register as one more word
	wire logic [PTR_W-1:0] fall_through_select_extra = PTR_W'(fall_through_select_mode);
	wire logic [PTR_W-1:0] total = mem_count + PTR_W'(fall_through_select_mode & out_valid);
	wire logic pae_raw = total <= (PTR_W'(empty_ofs) + fall_through_select_extra);
	wire logic paf_raw = total >= (DEPTH - PTR_W'(full_ofs) + fall_through_select_extra);
	wire logic hf_raw = total > (HALF_DEPTH + fall_through_select_extra);

	// mode-shared empty and full pins: empty/ready and full/input-ready
	wire logic next_empty_n = rst_active ? fall_through_select_mode
		: (fall_through_select_mode ? (next_rt_busy | !next_out_valid)
		: (!next_rt_busy & mem_nonempty));
	wire logic next_full_n = rst_active ? !fall_through_select_mode : (fall_through_select_mode ? wfull : !wfull);

	// strap capture after the master reset level is seen; async path only at power-up
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fall_through_select_mode <= MODE_STD;
			serial_method <= METHOD_PAR;
			ofs_lo <= '{default: OFS_DEF_PAR[OFS_LO_W-1:0]};
			ofs_hi <= '{default: OFS_DEF_PAR[OFS_W-1:OFS_LO_W]};
		end else if (mrs_low) begin
			fall_through_select_mode <= fall_through_select_in;
			serial_method <= load_select_n_in;
			ofs_lo <= '{default: def_ofs[OFS_LO_W-1:0]};
			ofs_hi <= '{default: def_ofs[OFS_W-1:OFS_LO_W]};
		end else if (ofs_wr) begin
			if (ofs_wptr[OPTR_HI_BIT]) begin
				ofs_hi[ofs_wptr[OPTR_SEL_BIT]] <= data_in_bus_in[OFS_HI_W-1:0];
			end else begin
				ofs_lo[ofs_wptr[OPTR_SEL_BIT]] <= data_in_bus_in[OFS_LO_W-1:0];
			end
		end
	end

	// offset pointers see only the master reset, so partial reset leaves them alone
	always_ff @(posedge clk_in or negedge mrst_n) begin
		if (!mrst_n) begin
			ofs_wptr <= OPTR_EMPTY_LO;
			ofs_rptr <= OPTR_EMPTY_LO;
		end else begin
			ofs_wptr <= ofs_wr ? ofs_wptr + OPTR_STEP : ofs_wptr;
			ofs_rptr <= ofs_rd ? ofs_rptr + OPTR_STEP : ofs_rptr;
		end
	end

	// pointers, output register and retransmit sequencing
	always_ff @(posedge clk_in or negedge prst_n) begin
		if (!prst_n) begin
			wptr <= PTR_ZERO;
			wptr_vis <= PTR_ZERO;
			rptr <= PTR_ZERO;
			out_valid <= 1'b0;
			data_out_bus_out <= DATA_ZERO;
			mem_wr_out <= '0;
			rt_state <= RT_IDLE;
			rt_cnt <= RT_CNT_ZERO;
		end else begin
			wptr <= mem_wr ? wptr + PTR_STEP : wptr;
			wptr_vis <= mem_wr_out.en ? wptr_vis + PTR_STEP : wptr_vis;
			rptr <= next_rptr;
			out_valid <= next_out_valid;
			data_out_bus_out <= next_data_out;
			mem_wr_out <= '{en: mem_wr, addr: wptr[ADDR_W-1:0], data: data_in_bus_in};
			rt_state <= next_rt_state;
			rt_cnt <= next_rt_cnt;
		end
	end

	// flags: empty/full follow the kept mode, hence resynchronised reset only
	logic empty_n, full_n, hf_n, pae_s1, pae_n, paf_s1, paf_n;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			empty_n <= MODE_STD;
			full_n <= !MODE_STD;
		end else begin
			empty_n <= next_empty_n;
			full_n <= next_full_n;
		end
	end

	// two-stage partial flags give the two-edge settling after an offset write
	always_ff @(posedge clk_in or negedge prst_n) begin
		if (!prst_n) begin
			hf_n <= HF_RST;
			pae_s1 <= PAE_RST;
			pae_n <= PAE_RST;
			paf_s1 <= PAF_RST;
			paf_n <= PAF_RST;
		end else begin
			hf_n <= !hf_raw;
			pae_s1 <= !pae_raw;
			pae_n <= pae_s1;
			paf_s1 <= !paf_raw;
			paf_n <= paf_s1;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fall_through_mode_out <= MODE_STD;
			serial_method_out <= METHOD_PAR;
		end else begin
			fall_through_mode_out <= fall_through_select_mode;
			serial_method_out <= serial_method;
		end
	end

	assign flags_out = '{empty_flag_n: empty_n, full_flag_n: full_n, half_full_flag_n: hf_n,
		almost_empty_flag_n: pae_n, almost_full_flag_n: paf_n};
	assign mem_rd_addr_out = rptr[ADDR_W-1:0];

	// checks
	default clocking dforc_cb @(posedge clk_in);
	endclocking
	default disable iff (!prst_n || rst_active);

	ofs_wr_wrap_a: assert property (
		ofs_wr |=> ofs_wptr == $past(ofs_wptr) + OPTR_STEP)
		else $error("offset write pointer did not advance");

	ofs_lo_store_a: assert property (
		ofs_wr && ofs_wptr == OPTR_EMPTY_LO |=> ofs_lo[OFS_SEL_EMPTY] ==
		$past(data_in_bus_in[OFS_LO_W-1:0]))
		else $error("empty offset low not stored");

	ofs_ptr_indep_a: assert property (
		ofs_wr && !ofs_rd |=> $stable(ofs_rptr))
		else $error("offset read pointer moved on a write");

	ofs_rd_data_a: assert property (
		ofs_rd |=> data_out_bus_out == $past(ofs_rd_word))
		else $error("offset read-back word missing");

	ofs_rd_pause_a: assert property (
		!ofs_rd |=> $stable(ofs_rptr))
		else $error("offset read pointer moved while paused");

	rt_std_flag_a: assert property (
		rt_start && !fall_through_select_mode && wptr_vis != PTR_ZERO && wptr_vis == wptr
		|=> !flags_out.empty_flag_n [*2] ##1 flags_out.empty_flag_n)
		else $error("standard retransmit empty sequence wrong");

	rt_fall_through_select_flag_a: assert property (
		rt_start && fall_through_select_mode |=> flags_out.empty_flag_n [*3])
		else $error("fall-through retransmit ready not held high");

	rt_home_a: assert property (
		rt_start |=> rptr == PTR_ZERO && rt_state == RT_SETUP)
		else $error("retransmit did not home the read pointer");

	pae_lat_a: assert property (
		##2 flags_out.almost_empty_flag_n == !$past(pae_raw, 2))
		else $error("almost-empty latency wrong");

	paf_lat_a: assert property (
		##2 flags_out.almost_full_flag_n == !$past(paf_raw, 2))
		else $error("almost-full latency wrong");

	mode_keep_a: assert property (
		##1 $stable(fall_through_select_mode) && $stable(serial_method))
		else $error("mode or method changed outside master reset");

	ofs_default_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		mrs_low && !load_select_n_in |=> empty_ofs == OFS_DEF_PAR && full_ofs == OFS_DEF_PAR)
		else $error("parallel default offsets not loaded");

	ofs_rd_wrap_a: assert property (
		ofs_rd |=> ofs_rptr == $past(ofs_rptr) + OPTR_STEP)
		else $error("offset read pointer did not advance");

	ofs_hi_store_a: assert property (
		ofs_wr && ofs_wptr == OPTR_EMPTY_LO + OPTR_STEP |=> ofs_hi[OFS_SEL_EMPTY] ==
		$past(data_in_bus_in[OFS_HI_W-1:0]))
		else $error("empty offset high not stored");

	ofs_ser_default_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		mrs_low && load_select_n_in |=> empty_ofs == OFS_DEF_SER && full_ofs == OFS_DEF_SER)
		else $error("serial default offsets not loaded");

	// serial method must leave the parallel write pointer parked
	ofs_wr_refuse_a: assert property (
		!write_en_n_in && !load_select_n_in && serial_method |=> $stable(ofs_wptr))
		else $error("offset write taken under serial method");

	ofs_no_mem_a: assert property (
		ofs_wr |=> !mem_wr_out.en)
		else $error("memory written during offset load");

	rt_refuse_a: assert property (
		rt_idle && !retransmit_n_in && !read_en_n_in |=> rt_state == RT_IDLE)
		else $error("retransmit taken with read enabled");

	rt_hf_a: assert property (
		rt_start |=> flags_out.half_full_flag_n == !$past(hf_raw))
		else $error("half flag not updated on setup edge");

	rt_fall_through_select_word_a: assert property (
		rt_start && fall_through_select_mode && wptr_vis != PTR_ZERO && wptr_vis == wptr
		|=> ##3 !flags_out.empty_flag_n)
		else $error("fall-through first word not presented");

	ofs_wrap_c: cover property (ofs_wr && ofs_wptr == OPTR_FULL_HI);
	rt_std_c: cover property (rt_start && !fall_through_select_mode);
	rt_fall_through_select_c: cover property (rt_start && fall_through_select_mode ##4 !flags_out.empty_flag_n);
	ofs_rd_c: cover property (ofs_rd ##1 rd_req);

endmodule : dforc_ctrl

`default_nettype wire

// [tb/dforc_ram_model.sv]
// behavioural external memory array beside the fifo controller
`timescale 1ns/10ps
`default_nettype none
module dforc_ram_model
	import dforc_pkg::*;
(
	input wire logic clk_in,
	input wire dforc_mem_wr_t mem_wr_in,
	input wire logic [ADDR_W-1:0] rd_addr_in,
	output wire logic [DATA_W-1:0] rd_data_out
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	// unwritten words hold an address-derived pattern, never zero or a stale word
	initial begin
		for (int i = 0; i < 2**ADDR_W; i++) begin
			mem[i] = {1'b1, ~i[ADDR_W-1:0]};
		end
	end
	always @(posedge clk_in) begin
		if (mem_wr_in.en) begin
			mem[mem_wr_in.addr] <= mem_wr_in.data;
		end
	end
	// combinational read, as the controller expects
	assign rd_data_out = mem[rd_addr_in];
endmodule : dforc_ram_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the offset, retransmit and reset control
`timescale 1ns/10ps
`default_nettype none
module testbench
	import dforc_pkg::*;
;
	logic clk_in, resetn_in, master_reset_n_in, partial_reset_n_in, fall_through_select_in;
	logic load_select_n_in, write_en_n_in, read_en_n_in, retransmit_n_in;
	logic [DATA_W-1:0] data_in_bus_in, mem_rd_data_in, data_out_bus_out;
	dforc_flags_t flags_out;
	dforc_mem_wr_t mem_wr_out;
	logic [ADDR_W-1:0] mem_rd_addr_out;
	logic fall_through_mode_out, serial_method_out;
	int err_count, checks_done, cycles;
	logic [DATA_W-1:0] wd [3] = '{18'h1_2345, 18'h2_0ABC, 18'h0_7777};

	dforc_ctrl u_dforc_ctrl (.clk_in(clk_in), .resetn_in(resetn_in),
		.master_reset_n_in(master_reset_n_in), .partial_reset_n_in(partial_reset_n_in),
		.fall_through_select_in(fall_through_select_in), .load_select_n_in(load_select_n_in),
		.write_en_n_in(write_en_n_in), .read_en_n_in(read_en_n_in),
		.retransmit_n_in(retransmit_n_in), .data_in_bus_in(data_in_bus_in),
		.mem_rd_data_in(mem_rd_data_in), .data_out_bus_out(data_out_bus_out),
		.flags_out(flags_out), .mem_wr_out(mem_wr_out), .mem_rd_addr_out(mem_rd_addr_out),
		.fall_through_mode_out(fall_through_mode_out), .serial_method_out(serial_method_out));
	dforc_ram_model u_dforc_ram_model (.clk_in(clk_in), .mem_wr_in(mem_wr_out),
		.rd_addr_in(mem_rd_addr_out), .rd_data_out(mem_rd_data_in));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task end_of_test;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// generous ceiling: the whole sequence needs under two hundred cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("ERROR t=%0t timeout", $time);
			end_of_test();
		end
	end

	task check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task chk_flags(input logic [4:0] exp);
		check({13'h0_000, flags_out}, {13'h0_000, exp});
	endtask : chk_flags

	task cyc(input logic ld, input logic we, input logic re, input logic [DATA_W-1:0] d);
		@(posedge clk_in);
		load_select_n_in <= ld;
		write_en_n_in <= we;
		read_en_n_in <= re;
		data_in_bus_in <= d;
	endtask : cyc

	// one request then idle; read and write enables never low together
	task op(input logic ld, input logic we, input logic re, input logic [DATA_W-1:0] d);
		cyc(ld, we, re, d);
		cyc(1'b1, 1'b1, 1'b1, 18'h0_0000);
		#1;
	endtask : op

	task ofs_rd(input logic [DATA_W-1:0] exp);
		op(1'b0, 1'b1, 1'b0, 18'h0_0000);
		check(data_out_bus_out, exp);
	endtask : ofs_rd

	task mem_rd(input logic [DATA_W-1:0] exp);
		op(1'b1, 1'b1, 1'b0, 18'h0_0000);
		check(data_out_bus_out, exp);
	endtask : mem_rd

	// held low well past the synchroniser, then a settle gap before traffic
	task rst(input logic mr, input logic ld, input logic ft);
		@(posedge clk_in);
		if (mr) begin
			master_reset_n_in <= 1'b0;
		end else begin
			partial_reset_n_in <= 1'b0;
		end
		load_select_n_in <= ld;
		fall_through_select_in <= ft;
		repeat (6) @(posedge clk_in);
		master_reset_n_in <= 1'b1;
		partial_reset_n_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		load_select_n_in <= 1'b1;
		@(posedge clk_in);
		#1;
	endtask : rst

	task fill;
		for (int i = 0; i < 3; i++) begin
			op(1'b1, 1'b0, 1'b1, wd[i]);
		end
		repeat (4) @(posedge clk_in);
		#1;
	endtask : fill

	// enables are already high when the request goes low
	task rt;
		@(posedge clk_in);
		retransmit_n_in <= 1'b0;
		@(posedge clk_in);
		retransmit_n_in <= 1'b1;
		@(posedge clk_in);
		#1;
	endtask : rt

	task wait_ef(input logic v);
		int n;
		n = 0;
		while (flags_out.empty_flag_n !== v && n < 12) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check({17'h0_0000, flags_out.empty_flag_n}, {17'h0_0000, v});
	endtask : wait_ef

	initial begin
		err_count = 0;
		checks_done = 0;
		cycles = 0;
		resetn_in = 1'b0;
		master_reset_n_in = 1'b0;
		partial_reset_n_in = 1'b1;
		fall_through_select_in = 1'b0;
		load_select_n_in = 1'b1;
		write_en_n_in = 1'b1;
		read_en_n_in = 1'b1;
		retransmit_n_in = 1'b1;
		data_in_bus_in = 18'h0_0000;
		repeat (16) @(posedge clk_in);
		resetn_in <= 1'b1;
		rst(1'b1, 1'b0, 1'b0);
		chk_flags(5'h0D);
		check(data_out_bus_out, 18'h0_0000);
		check({17'h0_0000, serial_method_out}, 18'h0_0000);
		ofs_rd(18'h0_007F);
		ofs_rd(18'h0_0000);
		ofs_rd(18'h0_007F);
		ofs_rd(18'h0_0000);
		// back-to-back loads, pause by enable, redirect to memory, then wrap
		cyc(1'b0, 1'b0, 1'b1, 18'h3_1234);
		cyc(1'b0, 1'b0, 1'b1, 18'h3_FFFF);
		cyc(1'b0, 1'b1, 1'b1, 18'h0_0000);
		op(1'b1, 1'b0, 1'b1, 18'h2_5A5A);
		op(1'b0, 1'b0, 1'b1, 18'h0_0456);
		op(1'b0, 1'b0, 1'b1, 18'h3_FFFE);
		op(1'b0, 1'b0, 1'b1, 18'h0_ABCD);
		repeat (3) @(posedge clk_in);
		ofs_rd(18'h0_ABCD);
		mem_rd(18'h2_5A5A);
		ofs_rd(18'h0_0001);
		ofs_rd(18'h0_0456);
		ofs_rd(18'h0_0000);
		ofs_rd(18'h0_ABCD);
		rst(1'b0, 1'b1, 1'b1);
		chk_flags(5'h0D);
		check(data_out_bus_out, 18'h0_0000);
		check({17'h0_0000, fall_through_mode_out}, 18'h0_0000);
		check({17'h0_0000, serial_method_out}, 18'h0_0000);
		ofs_rd(18'h0_0001);
		ofs_rd(18'h0_0456);
		rst(1'b1, 1'b1, 1'b0);
		check({17'h0_0000, serial_method_out}, 18'h0_0001);
		ofs_rd(18'h0_03FF);
		ofs_rd(18'h0_0000);
		// standard retransmit: two of three words read first
		rst(1'b1, 1'b0, 1'b0);
		fill();
		mem_rd(wd[0]);
		mem_rd(wd[1]);
		rt();
		check({17'h0_0000, flags_out.empty_flag_n}, 18'h0_0000);
		wait_ef(1'b1);
		check(data_out_bus_out, wd[1]);
		mem_rd(wd[0]);
		mem_rd(wd[1]);
		// fall-through mode: automatic first word, offset read, retransmit
		rst(1'b1, 1'b0, 1'b1);
		chk_flags(5'h15);
		check({17'h0_0000, fall_through_mode_out}, 18'h0_0001);
		fill();
		wait_ef(1'b0);
		check(data_out_bus_out, wd[0]);
		mem_rd(wd[1]);
		mem_rd(wd[2]);
		ofs_rd(18'h0_007F);
		rt();
		check({17'h0_0000, flags_out.empty_flag_n}, 18'h0_0001);
		wait_ef(1'b0);
		check(data_out_bus_out, wd[0]);
		mem_rd(wd[1]);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
